// >>> hw/mem_if.sv
// Single-port memory link between the sequencer and its memories.
// Assumes read data appear one clock after the address.
`default_nettype none

interface mem_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// >>> hw/seq_mem.sv
// Single-port synchronous memory with registered read data.
// Assumes the controller never reads and writes in one cycle.
`default_nettype none

module seq_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk,
  // Memory port
  mem_if.mem port
);
  logic [DW-1:0] store [2**AW];
  logic [DW-1:0] rdata_reg;

  initial begin
    if (AW < 1 || DW < 1) begin
      $error("seq_mem: bad geometry");
    end
  end

  always_ff @(posedge clk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
  end

  // Read data come from a register, never straight from the array
  always_ff @(posedge clk) begin
    rdata_reg <= store[port.addr];
  end

  assign port.rdata = rdata_reg;
endmodule

`default_nettype wire

// >>> hw/seq_pkg.sv
// Shared constants and types for the waveform segment sequencer.
// Assumes one 100 MHz clock domain and a synchronous reset.
`default_nettype none

package seq_pkg;
  // -----------------------------------------------------------------
  // Widths and sizes
  // -----------------------------------------------------------------
  localparam int SAMPLE_W = 16;
  localparam int ADDR_W = 20;
  localparam logic [20:0] HS_LIMIT = 21'h10_0000;
  localparam int ALIGN_LSB = 9;
  localparam int REPS_W = 8;
  localparam int LINES_STD = 512;
  localparam int LINES_BIG = 2048;
  localparam int LINE_AW = 11;
  localparam int RATE_W = 3;
  localparam int MEMBER_W = 4;
  localparam int SEG_W = 4;
  localparam int CH_W = 2;
  localparam int BUF_DEPTH = 2;
  localparam logic [MEMBER_W-1:0] FIRST_MEMBER = 4'h1;

  // -----------------------------------------------------------------
  // Types
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [RATE_W-1:0] rate;
    logic [REPS_W-1:0] reps;
    logic [ADDR_W-1:0] len;
    logic [ADDR_W-1:0] start;
  } line_t;

  localparam int LINE_DW = $bits(line_t);

  typedef enum logic [2:0] {
    S_IDLE,
    S_LOAD,
    S_FETCH,
    S_FIRST,
    S_PLAY
  } state_t;
endpackage

`default_nettype wire

// >>> hw/waveform_segment_sequencer.sv
// Segment sequencer: loads segments, plays lines, obeys group commands.
// Assumes load ports come from same-clock logic and command pins do not.
// Operation
// - Lines play in order, each segment repeated its line's count.
// - Group mode loads all member segments to fast memory before play.
// - Reject group whose padded sample total reaches one mebipoint; the last segment is counted without its padding.
// - Every segment starts on a 512-point boundary; gap is padding.
// - After loading, playback of the first group member starts alone.
// - Continuous mode replays current member until a command arrives.
// - Advance abandons the current member and starts the next one.
// - Jump abandons current member and starts the jump target member.
// - Reset acts as jump_target_index member one.
// - Commands act only when their channel selection matches ours.
// - One common rate: the fastest; mismatch is flagged to the user.
// - Standard mode reports per-line duration error, zero on same rate.
// - Group members are stored sequences kept in entry order.
// - Repetition counter holds up to 255 per line.
// - Line table holds 512 lines standard, 2048 enlarged; here it always has 2048 entries, LINES is only checked.
`default_nettype none

module waveform_segment_sequencer #(
  parameter int LINES = seq_pkg::LINES_BIG,
  parameter logic [seq_pkg::CH_W-1:0] CHANNEL = 2'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Segment loading
  input wire logic load_start,
  input wire logic load_done,
  input wire logic group_mode,
  input wire logic seg_begin,
  input wire logic [seq_pkg::SEG_W-1:0] seg_id,
  input wire logic [seq_pkg::ADDR_W-1:0] seg_len,
  input wire logic [seq_pkg::RATE_W-1:0] seg_rate,
  input wire logic sample_valid,
  input wire logic [seq_pkg::SAMPLE_W-1:0] sample_data,
  output logic sample_ready,
  // Line and member tables
  input wire logic line_wr,
  input wire logic [seq_pkg::LINE_AW-1:0] line_idx,
  input wire logic [seq_pkg::SEG_W-1:0] line_seg,
  input wire logic [seq_pkg::REPS_W-1:0] line_reps,
  input wire logic member_wr,
  input wire logic [seq_pkg::MEMBER_W-1:0] member_idx,
  input wire logic [seq_pkg::LINE_AW-1:0] member_first,
  input wire logic [seq_pkg::LINE_AW-1:0] member_last,
  // Command pins
  input wire logic cmd_advance_pin,
  input wire logic cmd_jump_pin,
  input wire logic cmd_reset_pin,
  input wire logic [seq_pkg::CH_W-1:0] cmd_channel_pin,
  input wire logic [seq_pkg::MEMBER_W-1:0] jump_target_index,
  // Sample stream
  output logic out_valid,
  output logic [seq_pkg::SAMPLE_W-1:0] out_data,
  input wire logic out_ready,
  // Status
  output logic group_reject,
  output logic rate_mismatch,
  output logic [seq_pkg::RATE_W-1:0] common_rate,
  output logic line_error,
  output logic playing,
  output logic [seq_pkg::MEMBER_W-1:0] member_now,
  output logic cmd_warning
);
  localparam int AW = seq_pkg::ADDR_W;
  localparam int LW = seq_pkg::LINE_AW;
  localparam int MW = seq_pkg::MEMBER_W;
  localparam int BW = seq_pkg::ADDR_W - seq_pkg::ALIGN_LSB + 1;

  initial begin
    if (LINES != seq_pkg::LINES_STD && LINES != seq_pkg::LINES_BIG) begin
      $error("LINES must be 512 or 2048");
    end
  end

  // -----------------------------------------------------------------
  // Memories
  // -----------------------------------------------------------------
  mem_if #(.AW(AW), .DW(seq_pkg::SAMPLE_W)) smp ();
  mem_if #(.AW(LW), .DW(seq_pkg::LINE_DW)) lin ();
  seq_mem #(.AW(AW), .DW(seq_pkg::SAMPLE_W)) u_smp (.clk(clk), .port(smp));
  seq_mem #(.AW(LW), .DW(seq_pkg::LINE_DW)) u_lin (.clk(clk), .port(lin));

  seq_pkg::state_t state_reg;
  seq_pkg::line_t cur_reg, nxt_reg, lin_rd;
  logic [AW:0] base_reg, seg_end, aligned;
  logic [BW-1:0] blk;
  logic [AW-1:0] wr_ptr_reg, pt_reg;
  logic [seq_pkg::REPS_W-1:0] rep_reg;
  logic [LW-1:0] cur_idx_reg, nxt_idx_reg, follow_idx, first_reg, last_reg;
  logic [MW-1:0] member_count_reg, target;
  logic nxt_valid_reg, nxt_pend_reg, infl_reg, seen_reg, overflow;
  logic [1:0] cnt_reg;
  logic [2:0] occ;
  logic [seq_pkg::SAMPLE_W-1:0] tail_reg;
  logic last_pt, last_rep, room, issue, pop, push, line_rd_go, cmd_take;
  logic [AW-1:0] seg_base [2**seq_pkg::SEG_W];
  logic [AW-1:0] seg_size [2**seq_pkg::SEG_W];
  logic [seq_pkg::RATE_W-1:0] seg_rt [2**seq_pkg::SEG_W];
  logic [LW-1:0] first_tab [2**MW];
  logic [LW-1:0] last_tab [2**MW];

  // -----------------------------------------------------------------
  // Command pin synchronisers
  // -----------------------------------------------------------------
  // Stage 1 feeds stage 2 only; edges are taken from stage 2 onward
  logic [3+seq_pkg::CH_W+MW-1:0] pin_s1, pin_s2;
  logic [2:0] cmd_old;
  logic adv_e, jmp_e, rst_e, any_e, jt_ok;
  logic [seq_pkg::CH_W-1:0] ch_s;
  logic [MW-1:0] jt_s;

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      cmd_old <= 3'h0;
    end else begin
      pin_s1 <= {cmd_advance_pin, cmd_jump_pin, cmd_reset_pin,
                 cmd_channel_pin, jump_target_index};
      pin_s2 <= pin_s1;
      cmd_old <= pin_s2[3+seq_pkg::CH_W+MW-1-:3];
    end
  end

  assign {adv_e, jmp_e, rst_e} = pin_s2[3+seq_pkg::CH_W+MW-1-:3] & ~cmd_old;
  assign ch_s = pin_s2[seq_pkg::CH_W+MW-1:MW];
  assign jt_s = pin_s2[MW-1:0];
  assign jt_ok = jt_s != '0 && jt_s <= member_count_reg;
  assign any_e = adv_e | (jmp_e & jt_ok) | rst_e;
  assign cmd_take = state_reg == seq_pkg::S_PLAY && group_mode &&
                    ch_s == CHANNEL && any_e && !load_start;

  // Reset outranks jump, jump outranks advance
  always_comb begin
    if (rst_e) begin
      target = seq_pkg::FIRST_MEMBER;
    end else if (jmp_e && jt_ok) begin
      target = jt_s;
    end else if (member_now >= member_count_reg) begin
      target = seq_pkg::FIRST_MEMBER;
    end else begin
      target = member_now + 4'h1;
    end
  end

  // -----------------------------------------------------------------
  // Segment loader
  // -----------------------------------------------------------------
  assign seg_end = base_reg + {1'b0, seg_len};
  assign overflow = seg_end >= seq_pkg::HS_LIMIT;
  assign blk = seg_end[AW:seq_pkg::ALIGN_LSB] +
               BW'(|seg_end[seq_pkg::ALIGN_LSB-1:0]);
  assign aligned = {blk, {seq_pkg::ALIGN_LSB{1'b0}}};

  always_ff @(posedge clk) begin
    if (srst) begin
      base_reg <= '0;
      wr_ptr_reg <= '0;
      group_reject <= 1'b0;
      rate_mismatch <= 1'b0;
      common_rate <= '0;
      seen_reg <= 1'b0;
      sample_ready <= 1'b0;
    end else begin
      sample_ready <= state_reg == seq_pkg::S_LOAD && !load_done &&
                      !group_reject && !(seg_begin && overflow);
      if ((state_reg == seq_pkg::S_IDLE || state_reg == seq_pkg::S_PLAY) &&
          load_start) begin
        base_reg <= '0;
        group_reject <= 1'b0;
        rate_mismatch <= 1'b0;
        common_rate <= '0;
        seen_reg <= 1'b0;
      end else if (state_reg == seq_pkg::S_LOAD && seg_begin &&
                   !group_reject) begin
        if (overflow) begin
          group_reject <= 1'b1;
        end else begin
          base_reg <= aligned;
          wr_ptr_reg <= base_reg[AW-1:0];
          seen_reg <= 1'b1;
          // Fastest clock wins; any difference is flagged
          if (seg_rate > common_rate) begin
            common_rate <= seg_rate;
          end
          if (seen_reg && seg_rate != common_rate) begin
            rate_mismatch <= 1'b1;
          end
        end
      end else if (sample_valid && sample_ready) begin
        wr_ptr_reg <= wr_ptr_reg + 20'h0_0001;
      end
    end
  end

  for (genvar g = 0; g < 2**seq_pkg::SEG_W; g++) begin : g_seg
    always_ff @(posedge clk) begin
      if (srst) begin
        seg_base[g] <= '0;
        seg_size[g] <= '0;
        seg_rt[g] <= '0;
      end else if (state_reg == seq_pkg::S_LOAD && seg_begin &&
                   !group_reject && !overflow &&
                   seg_id == seq_pkg::SEG_W'(g)) begin
        seg_base[g] <= base_reg[AW-1:0];
        seg_size[g] <= seg_len;
        seg_rt[g] <= seg_rate;
      end
    end
  end

  // Member table, 1-based, in entry order
  for (genvar m = 0; m < 2**MW; m++) begin : g_mem
    always_ff @(posedge clk) begin
      if (srst) begin
        first_tab[m] <= '0;
        last_tab[m] <= '0;
      end else if (member_wr && state_reg != seq_pkg::S_PLAY &&
                   member_idx == MW'(m)) begin
        first_tab[m] <= member_first;
        last_tab[m] <= member_last;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      member_count_reg <= '0;
    end else if (member_wr && state_reg != seq_pkg::S_PLAY &&
                 member_idx > member_count_reg) begin
      member_count_reg <= member_idx;
    end
  end

  // -----------------------------------------------------------------
  // Control state
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= seq_pkg::S_IDLE;
      member_now <= '0;
      first_reg <= '0;
      last_reg <= '0;
      cmd_warning <= 1'b0;
    end else begin
      cmd_warning <= state_reg == seq_pkg::S_PLAY && ch_s == CHANNEL &&
                     (adv_e | jmp_e | rst_e) && (!group_mode || !any_e);
      case (state_reg)
        seq_pkg::S_IDLE: begin
          if (load_start) begin
            state_reg <= seq_pkg::S_LOAD;
          end
        end
        seq_pkg::S_LOAD: begin
          // Playback waits until every segment is in place
          if (load_done) begin
            if (group_reject || member_count_reg == '0) begin
              state_reg <= seq_pkg::S_IDLE;
            end else begin
              state_reg <= seq_pkg::S_FETCH;
              member_now <= seq_pkg::FIRST_MEMBER;
              first_reg <= first_tab[seq_pkg::FIRST_MEMBER];
              last_reg <= last_tab[seq_pkg::FIRST_MEMBER];
            end
          end
        end
        seq_pkg::S_FETCH: state_reg <= seq_pkg::S_FIRST;
        seq_pkg::S_FIRST: state_reg <= seq_pkg::S_PLAY;
        default: begin
          if (load_start) begin
            state_reg <= seq_pkg::S_LOAD;
          end else if (cmd_take) begin
            state_reg <= seq_pkg::S_FETCH;
            member_now <= target;
            first_reg <= first_tab[target];
            last_reg <= last_tab[target];
          end
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Line playback
  // -----------------------------------------------------------------
  assign lin_rd = seq_pkg::line_t'(lin.rdata);
  // Wrapping to the first line keeps the member looping
  assign follow_idx = (cur_idx_reg == last_reg) ? first_reg :
                      cur_idx_reg + 11'h001;
  assign last_pt = pt_reg + 20'h0_0001 >= cur_reg.len;
  assign last_rep = {1'b0, rep_reg} + 9'h001 >= {1'b0, cur_reg.reps};
  assign pop = out_valid && out_ready;
  assign push = infl_reg;
  assign occ = {1'b0, cnt_reg} + {2'b00, infl_reg};
  assign room = occ < 3'h2 || (occ == 3'h2 && pop);
  assign issue = state_reg == seq_pkg::S_PLAY && room &&
                 !(last_pt && last_rep && !nxt_valid_reg);
  assign line_rd_go = state_reg == seq_pkg::S_PLAY && !nxt_valid_reg &&
                      !nxt_pend_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      cur_reg <= '0;
      nxt_reg <= '0;
      cur_idx_reg <= '0;
      nxt_idx_reg <= '0;
      pt_reg <= '0;
      rep_reg <= '0;
      nxt_valid_reg <= 1'b0;
      nxt_pend_reg <= 1'b0;
      line_error <= 1'b0;
    end else if (state_reg == seq_pkg::S_FIRST) begin
      cur_reg <= lin_rd;
      cur_idx_reg <= first_reg;
      pt_reg <= '0;
      rep_reg <= '0;
      nxt_valid_reg <= 1'b0;
      nxt_pend_reg <= 1'b0;
      line_error <= !group_mode && lin_rd.rate != common_rate;
    end else if (state_reg == seq_pkg::S_PLAY) begin
      // Prefetch keeps the next line ready before the current one ends
      if (line_rd_go) begin
        nxt_pend_reg <= 1'b1;
        nxt_idx_reg <= follow_idx;
      end
      if (nxt_pend_reg) begin
        nxt_reg <= lin_rd;
        nxt_valid_reg <= 1'b1;
        nxt_pend_reg <= 1'b0;
      end
      if (issue) begin
        pt_reg <= last_pt ? '0 : pt_reg + 20'h0_0001;
        if (last_pt && !last_rep) begin
          rep_reg <= rep_reg + 8'h01;
        end else if (last_pt) begin
          rep_reg <= '0;
          cur_reg <= nxt_reg;
          cur_idx_reg <= nxt_idx_reg;
          nxt_valid_reg <= 1'b0;
          line_error <= !group_mode && nxt_reg.rate != common_rate;
        end
      end
    end else begin
      nxt_valid_reg <= 1'b0;
      nxt_pend_reg <= 1'b0;
    end
  end

  assign smp.we = sample_valid && sample_ready;
  assign smp.addr = smp.we ? wr_ptr_reg : cur_reg.start + pt_reg;
  assign smp.wdata = sample_data;
  assign lin.we = line_wr && (state_reg == seq_pkg::S_IDLE ||
                              state_reg == seq_pkg::S_LOAD);
  assign lin.addr = lin.we ? line_idx :
                    (state_reg == seq_pkg::S_FETCH ? first_reg : follow_idx);
  assign lin.wdata = {seg_rt[line_seg], line_reps, seg_size[line_seg],
                      seg_base[line_seg]};

  // -----------------------------------------------------------------
  // Two-entry output buffer
  // -----------------------------------------------------------------
  // Issue is throttled by occupancy, so a stalled receiver loses nothing
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= 2'h0;
      out_valid <= 1'b0;
      out_data <= '0;
      tail_reg <= '0;
      infl_reg <= 1'b0;
      playing <= 1'b0;
    end else begin
      infl_reg <= issue;
      playing <= state_reg == seq_pkg::S_PLAY;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      out_valid <= (cnt_reg + {1'b0, push} - {1'b0, pop}) != 2'h0;
      if (pop && cnt_reg == 2'h2) begin
        out_data <= tail_reg;
        if (push) begin
          tail_reg <= smp.rdata;
        end
      end else if (push && (cnt_reg == 2'h0 || pop)) begin
        out_data <= smp.rdata;
      end else if (push) begin
        tail_reg <= smp.rdata;
      end
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_REJECT: assert property (
    state_reg == seq_pkg::S_LOAD && seg_begin && !group_reject && overflow
    |=> group_reject && !sample_ready)
    else $error("oversized group not rejected");
  AST_ALIGN: assert property (
    base_reg[seq_pkg::ALIGN_LSB-1:0] == '0)
    else $error("segment base not aligned");
  AST_AUTOSTART: assert property (
    state_reg == seq_pkg::S_LOAD && load_done && !group_reject &&
    member_count_reg != '0
    |=> state_reg == seq_pkg::S_FETCH && member_now == 4'h1
    ##1 state_reg == seq_pkg::S_FIRST ##1 state_reg == seq_pkg::S_PLAY)
    else $error("playback did not start after load");
  AST_ADVANCE: assert property (
    cmd_take && !rst_e && !(jmp_e && jt_ok) && member_now < member_count_reg
    |=> member_now == $past(member_now) + 4'h1 &&
        state_reg == seq_pkg::S_FETCH)
    else $error("advance went to wrong member");
  AST_JUMP: assert property (
    cmd_take && !rst_e && jmp_e && jt_ok |=> member_now == $past(jt_s))
    else $error("jump went to wrong member");
  AST_RESET: assert property (
    cmd_take && rst_e |=> member_now == 4'h1 ##2 playing == 1'b0)
    else $error("reset did not restart member one");
  AST_CHANNEL: assert property (
    state_reg == seq_pkg::S_PLAY && ch_s != CHANNEL && !load_start
    |=> state_reg == seq_pkg::S_PLAY && $stable(member_now))
    else $error("command acted on other channel");
  AST_LINE_STEP: assert property (
    issue && last_pt && last_rep
    |=> cur_idx_reg == $past(nxt_idx_reg) && pt_reg == '0 && rep_reg == '0)
    else $error("line change wrong");
  AST_NO_LOSS: assert property (
    push |-> cnt_reg != 2'h2 || pop)
    else $error("buffer overflow");
  AST_RATE: assert property (
    state_reg == seq_pkg::S_LOAD && seg_begin && !group_reject &&
    !overflow && seg_rate > common_rate |=> common_rate == $past(seg_rate))
    else $error("fastest rate not kept");
  AST_LINE_ERR: assert property (
    state_reg == seq_pkg::S_FIRST && lin_rd.rate == common_rate
    |=> !line_error)
    else $error("duration error not zero");

  COV_JUMP: cover property (cmd_take && jmp_e);
  COV_LINE: cover property (issue && last_pt && last_rep);
  COV_STALL: cover property (out_valid && !out_ready ##1 cnt_reg == 2'h2);
  COV_REJECT: cover property ($rose(group_reject));
endmodule

`default_nettype wire

// >>> verif/stream_sink.sv
// Output-stage model: accepts the sample stream with random stalls.
// Assumes the sequencer's valid/ready stream on the same clock.
`default_nettype none

module stream_sink (
  // Clock
  input wire logic clk,
  // Stream
  input wire logic out_valid,
  input wire logic [seq_pkg::SAMPLE_W-1:0] out_data,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [seq_pkg::SAMPLE_W-1:0] got [$];

  initial out_ready = 1'b0;
  // Stalls a quarter of the time so a held beat must not be lost
  always @(posedge clk) begin
    if (out_valid && out_ready)
      got.push_back(out_data);
    out_ready <= ($urandom % 4) != 0;
  end
endmodule

`default_nettype wire

// >>> verif/waveform_segment_sequencer_tb.sv
// Self-checking bench for the segment sequencer.
// Assumes the stream_sink model stands on the output side.
`default_nettype none

module waveform_segment_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, load_start, load_done, group_mode, seg_begin;
  logic [3:0] seg_id, member_idx, jump_target_index, member_now;
  logic [19:0] seg_len;
  logic [2:0] seg_rate, common_rate;
  logic sample_valid, sample_ready, line_wr, member_wr, out_valid, out_ready;
  logic [15:0] sample_data, out_data;
  logic [10:0] line_idx, member_first, member_last;
  logic [3:0] line_seg;
  logic [7:0] line_reps;
  logic cmd_advance_pin, cmd_jump_pin, cmd_reset_pin;
  logic [1:0] cmd_channel_pin;
  logic group_reject, rate_mismatch, line_error, playing, cmd_warning;
  logic [15:0] seg_data [0:3][0:3];
  int n_fail = 0;
  int n_compared = 0;
  int n_warn = 0;
  int n_lerr = 0;

  waveform_segment_sequencer uut (.clk(clk), .srst(srst),
    .load_start(load_start), .load_done(load_done), .group_mode(group_mode),
    .seg_begin(seg_begin), .seg_id(seg_id), .seg_len(seg_len),
    .seg_rate(seg_rate), .sample_valid(sample_valid),
    .sample_data(sample_data), .sample_ready(sample_ready),
    .line_wr(line_wr), .line_idx(line_idx), .line_seg(line_seg),
    .line_reps(line_reps), .member_wr(member_wr), .member_idx(member_idx),
    .member_first(member_first), .member_last(member_last),
    .cmd_advance_pin(cmd_advance_pin), .cmd_jump_pin(cmd_jump_pin),
    .cmd_reset_pin(cmd_reset_pin), .cmd_channel_pin(cmd_channel_pin),
    .jump_target_index(jump_target_index), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready),
    .group_reject(group_reject), .rate_mismatch(rate_mismatch),
    .common_rate(common_rate), .line_error(line_error), .playing(playing),
    .member_now(member_now), .cmd_warning(cmd_warning));
  stream_sink sink (.clk(clk), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready));

  // Warning pulses and line-error cycles are counted here so that none slips between checks
  always @(posedge clk) begin
    if (cmd_warning === 1'b1) n_warn++;
    if (line_error === 1'b1) n_lerr++;
  end

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Fewer samples than the length are sent only when the output samples are not checked
  task automatic send_seg(input logic [3:0] id, input logic [19:0] len,
      input logic [2:0] rate, input int ns);
    @(posedge clk);
    seg_begin <= 1'b1;
    seg_id <= id;
    seg_len <= len;
    seg_rate <= rate;
    for (int i = 0; i < ns; i++) begin
      @(posedge clk);
      seg_begin <= 1'b0;
      sample_valid <= 1'b1;
      sample_data <= seg_data[id][i];
    end
    @(posedge clk);
    seg_begin <= 1'b0;
    sample_valid <= 1'b0;
  endtask

  task automatic wr_table(input logic is_line, input int idx, input int a,
      input int b);
    @(posedge clk);
    line_wr <= is_line;
    member_wr <= !is_line;
    line_idx <= 11'(idx);
    member_idx <= 4'(idx);
    line_seg <= 4'(a);
    member_first <= 11'(a);
    line_reps <= 8'(b);
    member_last <= 11'(b);
    @(posedge clk);
    line_wr <= 1'b0;
    member_wr <= 1'b0;
  endtask

  // Member 1: seg 1 twice then seg 2 once; member 2: seg 2 three times
  task automatic load_group(input logic [2:0] r1, input logic [2:0] r2,
      input logic [19:0] len2, input int ns2);
    @(posedge clk);
    load_start <= 1'b1;
    @(posedge clk);
    load_start <= 1'b0;
    send_seg(4'h1, 20'h0_0004, r1, 4);
    send_seg(4'h2, len2, r2, ns2);
    wr_table(1'b1, 0, 1, 2);
    wr_table(1'b1, 1, 2, 1);
    wr_table(1'b1, 2, 2, 3);
    wr_table(1'b0, 1, 0, 1);
    wr_table(1'b0, 2, 2, 2);
    @(posedge clk);
    load_done <= 1'b1;
    @(posedge clk);
    load_done <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic send_cmd(input int kind, input logic [1:0] ch,
      input logic [3:0] tgt);
    @(posedge clk);
    cmd_channel_pin <= ch;
    jump_target_index <= tgt;
    repeat (4) @(posedge clk);
    cmd_advance_pin <= (kind == 0);
    cmd_jump_pin <= (kind == 1);
    cmd_reset_pin <= (kind == 2);
    repeat (8) @(posedge clk);
    {cmd_advance_pin, cmd_jump_pin, cmd_reset_pin} <= 3'h0;
    repeat (8) @(posedge clk);
  endtask

  function automatic logic [15:0] exp_sample(input int n);
    int p;
    p = n % 12;
    return (p < 8) ? seg_data[1][p % 4] : seg_data[2][p - 8];
  endfunction

  // -----------------------------------------------------------------
  // Sequence
  // -----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  initial begin
    int kind [7] = '{0, 0, 1, 2, 0, 1, 1};
    logic [1:0] chan [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0};
    logic [3:0] tgt [7] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h1, 4'h1, 4'h0};
    logic [3:0] want [7] = '{4'h2, 4'h1, 4'h2, 4'h1, 4'h1, 4'h1, 4'h1};
    int lerr_mark;
    srst = 1'b1;
    group_mode = 1'b1;
    {load_start, load_done, seg_begin, seg_id, seg_len, seg_rate} = '0;
    {sample_valid, sample_data, line_wr, line_idx, line_seg} = '0;
    {line_reps, member_wr, member_idx, member_first, member_last} = '0;
    {cmd_advance_pin, cmd_jump_pin, cmd_reset_pin} = 3'h0;
    {cmd_channel_pin, jump_target_index} = '0;
    void'($urandom(66));
    foreach (seg_data[i, j])
      seg_data[i][j] = 16'($urandom);
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    load_group(3'h2, 3'h2, 20'h0_0004, 4);
    check(playing === 1'b1 && member_now === 4'h1,
      "no auto start");
    check(rate_mismatch === 1'b0 && common_rate === 3'h2,
      "rate");
    for (int i = 0; i < 800 && sink.got.size() < 24; i++)
      @(posedge clk);
    for (int i = 0; i < 24; i++)
      check(sink.got[i] === exp_sample(i),
        "sample order");
    $display("test play done");
    tgt[5] = 4'(1 + $urandom % 2);
    want[5] = tgt[5];
    want[6] = tgt[5];
    for (int i = 0; i < 7; i++) begin
      send_cmd(kind[i], chan[i], tgt[i]);
      check(member_now === want[i] && playing === 1'b1,
        "command");
    end
    check(n_warn == 1, "bad target not warned");
    $display("test commands done");
    load_group(3'h1, 3'h3, 20'h0_0004, 4);
    check(rate_mismatch === 1'b1 && common_rate === 3'h3,
      "fastest");
    $display("test rates done");
    group_mode <= 1'b0;
    load_group(3'h1, 3'h3, 20'h0_0004, 4);
    check(n_lerr > 0, "rate error not reported");
    send_cmd(0, 2'h0, 4'h1);
    check(n_warn == 2 && member_now === 4'h1,
      "standard command");
    load_group(3'h2, 3'h2, 20'h0_0004, 4);
    lerr_mark = n_lerr;
    repeat (40) @(posedge clk);
    check(n_lerr == lerr_mark, "error on one rate");
    $display("test standard done");
    for (int t = 0; t < 2; t++) begin
      load_group(3'h2, 3'h2, t ? 20'hF_FE00 : 20'hF_FDFF, 0);
      check(group_reject === 1'(t), "reject bound");
      check(playing === !t, "play after load");
    end
    $display("test reject done");
    print_verdict();
  end
endmodule

`default_nettype wire
